// ---- pkg/fsp_regs.svh ----
`ifndef FSP_REGS_SVH
`define FSP_REGS_SVH

// bit positions within the 16-bit status word {high byte, low byte}
`define FSP_S_BUSY        0
`define FSP_S_LATCH       1
`define FSP_S_REGION_LO   2
`define FSP_S_REGION_HI   6
`define FSP_S_GUARD_LO    7
`define FSP_S_GUARD_HI    8
`define FSP_S_QUAD        9
`define FSP_S_OTP0        10
`define FSP_S_OTP1        11
`define FSP_S_DUMMY       12
`define FSP_S_RSVD        13
`define FSP_S_INVERT      14
`define FSP_S_SUSPEND     15

// reset value of the whole status word (delivery state)
`define FSP_STATUS_RESET  16'h0000

// dummy clock counts for the dual and quad i/o reads
`define FSP_DUAL_DUMMY_0  4'h4
`define FSP_DUAL_DUMMY_1  4'h8
`define FSP_QUAD_DUMMY_0  4'h6
`define FSP_QUAD_DUMMY_1  4'hA

// array geometry: 2 MB, 64 KB blocks, 4 KB sectors
`define FSP_ADDR_W        21
`define FSP_ARRAY_TOP     21'h1FFFFF
`define FSP_BLOCK_SHIFT   5'h10
`define FSP_SECTOR_SHIFT  5'h0C

// idle levels of the synchronised pins {write_guard_n, si, cs_n, sclk}
`define FSP_PIN_IDLE      4'hE

`endif

// ---- pkg/fsp_pkg.sv ----
package fsp_pkg;

    typedef enum logic [7:0] {
        FSP_CMD_NONE     = 8'b0000_0000,
        FSP_CMD_STATUS_WRITE_CMD     = 8'b0000_0001,
        FSP_CMD_PP       = 8'b0000_0010,
        FSP_CMD_WRDI     = 8'b0000_0100,
        FSP_CMD_RDSR_LO  = 8'b0000_0101,
        FSP_CMD_WRITE_ENABLE_CMD     = 8'b0000_0110,
        FSP_CMD_SE       = 8'b0010_0000,
        FSP_CMD_RDSR_HI  = 8'b0011_0101,
        FSP_CMD_BE32     = 8'b0101_0010,
        FSP_CMD_CE_A     = 8'b0110_0000,
        FSP_CMD_RST_EN   = 8'b0110_0110,
        FSP_CMD_SUSPEND  = 8'b0111_0101,
        FSP_CMD_RESUME   = 8'b0111_1010,
        FSP_CMD_RST      = 8'b1001_1001,
        FSP_CMD_CE_B     = 8'b1100_0111,
        FSP_CMD_BE64     = 8'b1101_1000
    } fsp_cmd_t;

    typedef enum logic [1:0] {
        FSP_GUARD_SOFT   = 2'b00,
        FSP_GUARD_PIN    = 2'b01,
        FSP_GUARD_POWER  = 2'b10,
        FSP_GUARD_OTP    = 2'b11
    } fsp_guard_t;

endpackage

// ---- verilog/fsp_sync2.sv ----
`timescale 1ns/1ps
// two-stage synchroniser, only the second stage leaves this module
module fsp_sync2 #(
    parameter int unsigned       WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // pins in, synchronised copy out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta     <= INIT;
            sync_out <= INIT;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ---- verilog/fsp_region_decode.sv ----
`timescale 1ns/1ps
`include "fsp_regs.svh"
module fsp_region_decode (
    // protection settings
    input  wire logic [4:0]              region_sel,
    input  wire logic                    region_invert,
    // address under test
    input  wire logic [`FSP_ADDR_W-1:0]  addr,
    output logic                         is_protected
);
    logic [2:0]             code;
    logic [4:0]             k;
    logic [`FSP_ADDR_W-1:0] hi;
    logic [`FSP_ADDR_W-1:0] lim;
    logic                   plain;

    always_comb begin
        code  = region_sel[2:0];
        k     = `FSP_BLOCK_SHIFT;
        plain = 1'b0;
        if (!region_sel[4]) begin
            k = `FSP_BLOCK_SHIFT + 5'(code) - 5'h01;
        end else if (code[2]) begin
            k = `FSP_SECTOR_SHIFT + 5'h03;
        end else begin
            k = `FSP_SECTOR_SHIFT + 5'(code) - 5'h01;
        end
        hi  = addr >> k;
        lim = `FSP_ARRAY_TOP >> k;
        // region_sel_3 picks top (0) or bottom (1) of the array
        if (code == 3'b000) begin
            plain = 1'b0;
        end else if (code[2:1] == 2'b11) begin
            plain = 1'b1;
        end else if (!region_sel[3]) begin
            plain = (hi == lim);
        end else begin
            plain = (hi == '0);
        end
        // invert flips every region into its complement
        is_protected = region_invert ? !plain : plain;
    end
endmodule

// ---- verilog/fsp_status_protect.sv ----
`timescale 1ns/1ps
`include "fsp_regs.svh"
// Functional notes
// - low byte: guard_lo, region_sel, latch, busy
// - high byte: suspend, invert, rsvd, dummy, locks, quad, guard_hi
// - busy high during program, erase, status write
// - latch clear refuses writes, programs and erases
// - program and erase blocked inside protected region
// - region bits writable only without hardware protection
// - full wipe only for all-zero or all-one codes
// - inverted: code 000 all, 11x none
// - inverted 00: lower fractions protected
// - inverted 01: upper fractions protected
// - inverted 10: all except top sectors
// - inverted 11: all except bottom sectors
// - guard 00: writes need only the latch
// - guard 01 with pin low: locked, except while quad is on
// - guard 01 with pin high: latch suffices
// - guard 10: locked until power cycle
// - guard 11: status locked until power cycle
// - quad bit turns control pins into data
// - lock bits set once, cleared only by power cycle
// - dummy bit selects read dummy clocks
// - dual 4 or 8, quad 6 or 10
// - suspend set by 75, cleared by resume/reset
// - latch set by enable, cleared by writes
// - normal mode protects complement of inverted region
module fsp_status_protect
    import fsp_pkg::*;
#(
    parameter int unsigned BUSY_CYCLES = 1000
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    arst_n,
    // serial link
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    si,
    output logic                         so,
    output logic                         so_oe,
    // write-guard pin
    input  wire logic                    write_guard_n,
    // status and configuration
    output logic                         busy_flag,
    output logic                         write_latch,
    output logic                         suspend_flag,
    output logic                         quad_pins_on,
    output logic                         guard_pin_active,
    output logic                         pause_pin_active,
    output logic [1:0]                   otp_lock,
    output logic [3:0]                   dual_dummy,
    output logic [3:0]                   quad_dummy,
    // array operation start
    output logic                         array_start,
    output fsp_pkg::fsp_cmd_t            array_op,
    output logic [`FSP_ADDR_W-1:0]       array_addr
);
    import fsp_pkg::*;

    localparam int unsigned CW = $clog2(BUSY_CYCLES + 1);

    logic [1:0]              rst_sync;
    logic                    rst_n;
    logic [3:0]              pins;
    logic                    s_sclk;
    logic                    s_cs_n;
    logic                    s_si;
    logic                    s_wp_n;
    logic                    p_sclk;
    logic                    p_cs_n;
    logic                    sclk_rise;
    logic                    sclk_fall;
    logic                    cs_rise;
    logic [2:0]              bit_cnt;
    logic [2:0]              byte_idx;
    logic [6:0]              shreg;
    logic [7:0]              new_byte;
    fsp_cmd_t                cmd;
    logic [23:0]             addr;
    logic [7:0]              d_lo;
    logic [7:0]              d_hi;
    logic                    rd_active;
    logic [7:0]              out_sr;
    logic [7:0]              rd_sel;
    logic                    guard_lo;
    logic                    guard_hi;
    logic [4:0]              region_sel;
    logic                    region_invert;
    logic                    dummy_sel;
    logic [15:0]             status;
    logic [15:0]             wr_word;
    fsp_guard_t              guard;
    logic                    wp_level;
    logic                    sr_ok;
    logic                    in_region;
    logic                    full_ok;
    logic                    exec;
    logic                    do_write_enable_cmd;
    logic                    do_wrdi;
    logic                    do_status_write_cmd;
    logic                    sr_accept;
    logic                    do_pp;
    logic                    do_er;
    logic                    do_ce;
    logic                    start;
    logic                    sw_reset;
    logic                    rst_armed;
    logic [CW-1:0]           busy_cnt;

    // reset release through two flops
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    fsp_sync2 #(
        .WIDTH (4),
        .INIT  (`FSP_PIN_IDLE)
    ) u_pins (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in ({write_guard_n, si, cs_n, sclk}),
        .sync_out (pins)
    );
    assign {s_wp_n, s_si, s_cs_n, s_sclk} = pins;

    // edge detection on the synchronised link clock and select
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            p_sclk <= 1'b0;
            p_cs_n <= 1'b1;
        end else begin
            p_sclk <= s_sclk;
            p_cs_n <= s_cs_n;
        end
    end
    assign sclk_rise = s_sclk && !p_sclk && !s_cs_n;
    assign sclk_fall = !s_sclk && p_sclk && !s_cs_n;
    assign cs_rise   = s_cs_n && !p_cs_n;
    assign new_byte  = {shreg, s_si};

    // byte assembly; command, address and status data bytes
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt  <= 3'h0;
            byte_idx <= 3'h0;
            shreg    <= 7'h00;
            cmd      <= FSP_CMD_NONE;
            addr     <= 24'h000000;
            d_lo     <= 8'h00;
            d_hi     <= 8'h00;
        end else if (s_cs_n) begin
            bit_cnt  <= 3'h0;
            byte_idx <= 3'h0;
        end else if (sclk_rise) begin
            shreg   <= new_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
                if (byte_idx != 3'h7) begin
                    byte_idx <= byte_idx + 3'h1;
                end
                if (byte_idx == 3'h0) begin
                    cmd <= fsp_cmd_t'(new_byte);
                end
                if (byte_idx >= 3'h1 && byte_idx <= 3'h3) begin
                    addr <= {addr[15:0], new_byte};
                end
                if (byte_idx == 3'h1) begin
                    d_lo <= new_byte;
                end
                if (byte_idx == 3'h2) begin
                    d_hi <= new_byte;
                end
            end
        end
    end

    assign status = {suspend_flag, region_invert, 1'b0, dummy_sel,
                     otp_lock, quad_pins_on, guard_hi,
                     guard_lo, region_sel, write_latch, busy_flag};

    // status read-out, shifted on falling link clock edges
    assign rd_sel = (byte_idx == 3'h0) ? new_byte : cmd;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_active <= 1'b0;
            out_sr    <= 8'h00;
            so        <= 1'b0;
            so_oe     <= 1'b0;
        end else begin
            so_oe <= rd_active && !s_cs_n;
            if (s_cs_n) begin
                rd_active <= 1'b0;
            end else if (sclk_rise && bit_cnt == 3'h7) begin
                // reload at every byte boundary: repeated reads stay live
                if (rd_sel == FSP_CMD_RDSR_LO) begin
                    rd_active <= 1'b1;
                    out_sr    <= status[7:0];
                end else if (rd_sel == FSP_CMD_RDSR_HI) begin
                    rd_active <= 1'b1;
                    out_sr    <= status[15:8];
                end
            end else if (sclk_fall && rd_active) begin
                so     <= out_sr[7];
                out_sr <= {out_sr[6:0], 1'b0};
            end
        end
    end

    // commands execute only when select rises on a byte boundary
    assign exec     = cs_rise && bit_cnt == 3'h0 && byte_idx != 3'h0;
    assign guard    = fsp_guard_t'({guard_hi, guard_lo});
    // the guard pin is data while quad mode is on, so it cannot lock
    assign wp_level = quad_pins_on ? 1'b1 : s_wp_n;

    always_comb begin
        case (guard)
            FSP_GUARD_SOFT:  sr_ok = 1'b1;
            FSP_GUARD_PIN:   sr_ok = wp_level;
            FSP_GUARD_POWER: sr_ok = 1'b0;
            FSP_GUARD_OTP:   sr_ok = 1'b0;
            default:         sr_ok = 1'b0;
        endcase
    end

    fsp_region_decode u_region (
        .region_sel    (region_sel),
        .region_invert (region_invert),
        .addr          (addr[`FSP_ADDR_W-1:0]),
        .is_protected  (in_region)
    );

    assign full_ok = (region_sel[2:0] == 3'b000 && !region_invert) ||
                     (region_sel[2:0] == 3'b111 && region_invert);

    assign do_write_enable_cmd   = exec && !busy_flag && cmd == FSP_CMD_WRITE_ENABLE_CMD;
    assign do_wrdi   = exec && !busy_flag && cmd == FSP_CMD_WRDI;
    assign do_status_write_cmd   = exec && !busy_flag && write_latch &&
                       cmd == FSP_CMD_STATUS_WRITE_CMD && byte_idx >= 3'h2;
    assign sr_accept = do_status_write_cmd && sr_ok;
    assign do_pp     = exec && !busy_flag && write_latch &&
                       cmd == FSP_CMD_PP && byte_idx >= 3'h5;
    assign do_er     = exec && !busy_flag && write_latch &&
                       byte_idx == 3'h4 &&
                       (cmd == FSP_CMD_SE || cmd == FSP_CMD_BE32 ||
                        cmd == FSP_CMD_BE64);
    assign do_ce     = exec && !busy_flag && write_latch &&
                       byte_idx == 3'h1 &&
                       (cmd == FSP_CMD_CE_A || cmd == FSP_CMD_CE_B);
    assign start     = sr_accept || ((do_pp || do_er) && !in_region) ||
                       (do_ce && full_ok);
    assign sw_reset  = exec && rst_armed && cmd == FSP_CMD_RST;

    // software reset needs the enable as the command just before it
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_armed <= 1'b0;
        end else if (exec) begin
            rst_armed <= (cmd == FSP_CMD_RST_EN);
        end
    end

    // single-byte write keeps the high byte as it is
    assign wr_word = {(byte_idx >= 3'h3) ? d_hi : status[15:8], d_lo};

    // non-volatile bits; only a power cycle returns them to reset
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {region_invert, dummy_sel, otp_lock, quad_pins_on,
             guard_hi, guard_lo, region_sel} <= 12'h000;
        end else if (sr_accept) begin
            guard_lo      <= wr_word[`FSP_S_GUARD_LO];
            region_sel    <= wr_word[`FSP_S_REGION_HI:`FSP_S_REGION_LO];
            guard_hi      <= wr_word[`FSP_S_GUARD_HI];
            quad_pins_on  <= wr_word[`FSP_S_QUAD];
            dummy_sel     <= wr_word[`FSP_S_DUMMY];
            region_invert <= wr_word[`FSP_S_INVERT];
            // lock bits only ever accumulate ones
            otp_lock <= otp_lock |
                        wr_word[`FSP_S_OTP1:`FSP_S_OTP0];
        end
    end

    // write latch: every complete write-type command taken while not busy clears it, refused by protection or not
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            write_latch <= 1'(`FSP_STATUS_RESET >> `FSP_S_LATCH);
        end else if (do_write_enable_cmd) begin
            write_latch <= 1'b1;
        end else if (do_wrdi || do_status_write_cmd || do_pp || do_er || do_ce ||
                     sw_reset) begin
            write_latch <= 1'b0;
        end
    end

    // busy timer; it holds while suspended
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            busy_flag <= 1'b0;
            busy_cnt  <= '0;
        end else if (sw_reset) begin
            busy_flag <= 1'b0;
            busy_cnt  <= '0;
        end else if (start) begin
            busy_flag <= 1'b1;
            busy_cnt  <= CW'(BUSY_CYCLES - 1);
        end else if (busy_flag && !suspend_flag) begin
            if (busy_cnt == '0) begin
                busy_flag <= 1'b0;
            end else begin
                busy_cnt <= busy_cnt - 1'b1;
            end
        end
    end

    // suspend applies to array work only, never to a status write
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            suspend_flag <= 1'b0;
        end else if (sw_reset) begin
            suspend_flag <= 1'b0;
        end else if (exec && cmd == FSP_CMD_SUSPEND && busy_flag &&
                     array_op != FSP_CMD_STATUS_WRITE_CMD) begin
            suspend_flag <= 1'b1;
        end else if (exec && cmd == FSP_CMD_RESUME) begin
            suspend_flag <= 1'b0;
        end
    end

    // array operation handoff
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            array_start <= 1'b0;
            array_op    <= FSP_CMD_NONE;
            array_addr  <= '0;
        end else begin
            array_start <= start;
            if (start) begin
                array_op   <= cmd;
                array_addr <= addr[`FSP_ADDR_W-1:0];
            end
        end
    end

    // pin roles and dummy counts
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            guard_pin_active <= 1'b1;
            pause_pin_active <= 1'b1;
            dual_dummy       <= `FSP_DUAL_DUMMY_0;
            quad_dummy       <= `FSP_QUAD_DUMMY_0;
        end else begin
            // tied control pins must never see quad mode drive them
            guard_pin_active <= !quad_pins_on;
            pause_pin_active <= !quad_pins_on;
            dual_dummy <= dummy_sel ? `FSP_DUAL_DUMMY_1
                                    : `FSP_DUAL_DUMMY_0;
            quad_dummy <= dummy_sel ? `FSP_QUAD_DUMMY_1
                                    : `FSP_QUAD_DUMMY_0;
        end
    end
endmodule

// ---- tb/fsp_status_protect_properties.sv ----
`timescale 1ns/1ps
module fsp_status_protect_properties #(
    parameter int unsigned BUSY_CYCLES = 1000
) (
    // clock and reset
    input wire logic       mclk,
    input wire logic       arst_n,
    // watched outputs
    input wire logic       busy_flag,
    input wire logic       write_latch,
    input wire logic       suspend_flag,
    input wire logic       quad_pins_on,
    input wire logic       guard_pin_active,
    input wire logic       pause_pin_active,
    input wire logic [1:0] otp_lock,
    input wire logic [3:0] dual_dummy,
    input wire logic [3:0] quad_dummy,
    input wire logic       array_start
);
    int busy_len;
    // one cycle of slack either way; suspended cycles do not count
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            busy_len <= 0;
        end else begin
            busy_len <= busy_flag ? busy_len + (suspend_flag ? 0 : 1) : 0;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_busy_len;
        $fell(busy_flag) |-> busy_len >= BUSY_CYCLES - 1
            && busy_len <= BUSY_CYCLES + 1;
    endproperty
    a_busy_len: assert property (p_busy_len)
        else $error("busy length differs from setting");
    property p_busy_cause;
        $rose(busy_flag) |-> array_start;
    endproperty
    a_busy_cause: assert property (p_busy_cause)
        else $error("busy rose without a launch");
    property p_start_busy;
        array_start |-> busy_flag;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("launch without busy");
    property p_had_latch;
        array_start |-> $past(write_latch);
    endproperty
    a_had_latch: assert property (p_had_latch)
        else $error("launch without write latch");
    property p_clr_latch;
        array_start |-> !write_latch;
    endproperty
    a_clr_latch: assert property (p_clr_latch)
        else $error("write latch kept after launch");
    property p_otp;
        (otp_lock & $past(otp_lock)) == $past(otp_lock);
    endproperty
    a_otp: assert property (p_otp)
        else $error("lock bit cleared");
    property p_dummy;
        (dual_dummy == 4'h4 && quad_dummy == 4'h6)
            || (dual_dummy == 4'h8 && quad_dummy == 4'hA);
    endproperty
    a_dummy: assert property (p_dummy)
        else $error("dummy counts not a legal pair");
    property p_role;
        $rose(quad_pins_on) |=> !guard_pin_active && !pause_pin_active;
    endproperty
    a_role: assert property (p_role)
        else $error("pins kept control role with quad on");
endmodule
bind fsp_status_protect fsp_status_protect_properties #(
    .BUSY_CYCLES(BUSY_CYCLES)
) i_fsp_status_protect_properties (
    .mclk, .arst_n, .busy_flag, .write_latch, .suspend_flag, .quad_pins_on,
    .guard_pin_active, .pause_pin_active, .otp_lock, .dual_dummy,
    .quad_dummy, .array_start
);

// ---- tb/fsp_host_model.sv ----
`timescale 1ns/1ps
module fsp_host_model (
    // clock
    input  wire logic mclk,
    // link
    input  wire logic so,
    output logic      sclk,
    output logic      cs_n,
    output logic      si
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        si   = 1'b1;
    end
    // mode 0, one sclk period is 8 mclk; rx keeps the last byte read
    task automatic xfer(input logic [39:0] tx, input int nb,
                        output logic [7:0] rx);
        rx = 8'h00;
        @(posedge mclk);
        cs_n <= 1'b0;
        for (int i = 0; i < nb * 8; i++) begin
            si <= tx[39 - i];
            repeat (4) @(posedge mclk);
            sclk <= 1'b1;
            repeat (4) @(posedge mclk);
            // so lags the fall by a few mclk, so sample late
            rx = {rx[6:0], so};
            sclk <= 1'b0;
        end
        repeat (4) @(posedge mclk);
        cs_n <= 1'b1;
        // released line flips so a stale bit never looks valid
        si <= ~si;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
    import fsp_pkg::*;
    logic        mclk, arst_n, write_guard_n, sclk, cs_n, si, so;
    logic        busy_flag, write_latch, suspend_flag, quad_pins_on;
    logic        guard_pin_active, pause_pin_active, array_start, started, e;
    logic [1:0]  otp_lock;
    logic [3:0]  dual_dummy, quad_dummy;
    fsp_cmd_t    array_op, st_op;
    logic [20:0] array_addr, st_addr;
    logic [7:0]  rx, lo, hi, c;
    logic [15:0] s;
    logic [23:0] a;
    int          err_count, checks;
    // {lo, hi, command, address, launched}
    logic [48:0] tbl [15] = '{
        {8'h04, 8'h40, 8'h20, 24'h1EF000, 1'b0},
        {8'h04, 8'h40, 8'h20, 24'h1F0000, 1'b1},
        {8'h24, 8'h40, 8'h20, 24'h00F000, 1'b1},
        {8'h24, 8'h40, 8'hD8, 24'h010000, 1'b0},
        {8'h44, 8'h40, 8'h52, 24'h1FF000, 1'b1},
        {8'h44, 8'h40, 8'h20, 24'h1FE000, 1'b0},
        {8'h64, 8'h40, 8'h20, 24'h000800, 1'b1},
        {8'h64, 8'h40, 8'h02, 24'h001000, 1'b0},
        {8'h00, 8'h40, 8'h20, 24'h000000, 1'b0},
        {8'h18, 8'h40, 8'h20, 24'h123000, 1'b1},
        {8'h04, 8'h00, 8'h20, 24'h1F0000, 1'b0},
        {8'h04, 8'h00, 8'h02, 24'h1EF000, 1'b1},
        {8'h1C, 8'h40, 8'hC7, 24'h000000, 1'b1},
        {8'h00, 8'h00, 8'h60, 24'h000000, 1'b1},
        {8'h04, 8'h00, 8'hC7, 24'h000000, 1'b0}
    };
    // long enough that a suspend can be sent while an erase runs
    fsp_status_protect #(.BUSY_CYCLES(100)) i_fsp_status_protect (
        .mclk, .arst_n, .sclk, .cs_n, .si, .so, .so_oe(),
        .write_guard_n, .busy_flag, .write_latch, .suspend_flag,
        .quad_pins_on, .guard_pin_active, .pause_pin_active,
        .otp_lock, .dual_dummy, .quad_dummy, .array_start, .array_op,
        .array_addr
    );
    fsp_host_model i_fsp_host_model (.mclk, .so, .sclk, .cs_n, .si);
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (array_start === 1'b1) begin
            started = 1'b1;
            st_addr = array_addr;
            st_op   = array_op;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [39:0] tx, input int nb);
        i_fsp_host_model.xfer(tx, nb, rx);
    endtask
    task automatic wr(input logic [7:0] l, input logic [7:0] h);
        send(40'h0600000000, 1);
        started = 1'b0;
        send({8'h01, l, h, 16'h0000}, 3);
    endtask
    task automatic rd();
        send(40'h0500000000, 2);
        s[7:0] = rx;
        send(40'h3500000000, 2);
        s[15:8] = rx;
    endtask
    task automatic idle();
        for (int i = 0; i < 200 && busy_flag !== 1'b0; i++) @(posedge mclk);
        if (busy_flag !== 1'b0) begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic power_cycle();
        arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        arst_n = 1'b0;
        write_guard_n = 1'b1;
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        rd();
        chk({s, dual_dummy, quad_dummy}, 24'h000046);
        send(40'h0600000000, 1);
        rd();
        chk(s, 16'h0002);
        send(40'h0400000000, 1);
        started = 1'b0;
        send(40'h0104000000, 3);
        chk({started, write_latch}, 2'b00);
        wr(8'h07, 8'hF4);
        chk({busy_flag, write_latch, started, st_op}, 11'h501);
        idle();
        rd();
        chk({s, dual_dummy, quad_dummy}, 24'h54048A);
        wr(8'h00, 8'h00);
        idle();
        chk(otp_lock, 2'b01);
        foreach (tbl[i]) begin
            {lo, hi, c, a, e} = tbl[i];
            wr(lo, hi);
            idle();
            send(40'h0600000000, 1);
            started = 1'b0;
            send({c, a, 8'hA5}, (c == 8'h02) ? 5
                 : ((c == 8'h60 || c == 8'hC7) ? 1 : 4));
            chk({started, write_latch}, {e, 1'b0});
            if (e && a != 24'h0) chk({st_op, st_addr}, {c, a[20:0]});
            idle();
        end
        wr(8'h80, 8'h00);
        idle();
        write_guard_n <= 1'b0;
        wr(8'h04, 8'h00);
        rd();
        chk({started, write_latch, s}, 18'h00480);
        write_guard_n <= 1'b1;
        wr(8'h00, 8'h01);
        chk(started, 1'b1);
        idle();
        wr(8'h04, 8'h00);
        rd();
        chk({started, s}, 17'h00500);
        power_cycle();
        rd();
        chk(s, 16'h0000);
        write_guard_n <= 1'b0;
        wr(8'h80, 8'h01);
        chk(started, 1'b1);
        idle();
        wr(8'h00, 8'h00);
        rd();
        chk({started, s}, 17'h00180);
        power_cycle();
        write_guard_n <= 1'b1;
        // guard pin is driven here, never tied, so the data role is safe
        wr(8'h00, 8'h02);
        idle();
        chk({quad_pins_on, guard_pin_active, pause_pin_active}, 3'b100);
        send(40'h0600000000, 1);
        send(40'h2000000000, 4);
        send(40'h7500000000, 1);
        rd();
        chk(s[15], 1'b1);
        send(40'h7A00000000, 1);
        chk(suspend_flag, 1'b0);
        send(40'h0600000000, 1);
        send(40'h7500000000, 1);
        send(40'h6600000000, 1);
        send(40'h9900000000, 1);
        chk({suspend_flag, write_latch}, 2'b00);
        complete_run();
    end
endmodule
